/* uff_fifo_flow_cfg.sv */
`timescale 1ns/1ns
module uff_fifo_flow_cfg (
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    input  wire logic [2:0]          reg_addr_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    input  wire logic [7:0]          reg_wdata_in,
    output logic      [7:0]          reg_rdata_out,
    input  wire logic [7:0]          line_control_in,
    input  wire logic                extra_feature_lock_in,
    input  wire logic                ier_sleep_in,
    input  wire logic                mcr_rts_in,
    input  wire logic                cts_n_in,
    input  wire logic                rx_byte_valid_in,
    input  wire logic [7:0]          rx_byte_in,
    input  wire logic [7:0]          resume_char_first_in,
    input  wire logic [7:0]          resume_char_second_in,
    input  wire logic [7:0]          pause_char_first_in,
    input  wire logic [7:0]          pause_char_second_in,
    input  wire logic [6:0]          rx_fill_in,
    input  wire logic [6:0]          tx_free_in,
    output uff_pkg::uff_fifo_cfg_t   fifo_cfg_out,
    output logic      [7:0]          efc_out,
    output logic      [6:0]          fifo_depth_out,
    output logic      [6:0]          rx_trig_level_out,
    output logic      [6:0]          tx_trig_level_out,
    output logic                     tx_fifo_clear_out,
    output logic                     rx_fifo_clear_out,
    output logic                     rx_data_avail_out,
    output logic                     tx_ready_out,
    output logic                     tx_cts_allow_out,
    output logic                     rts_n_out,
    output uff_pkg::uff_rx_evt_t     rx_evt_out,
    output logic                     tx_send_first_out,
    output logic                     tx_send_second_out,
    output logic                     enh_unlock_out,
    output logic                     sleep_allow_out
);
    // ----------------------------------------
    // Decoders
    // ----------------------------------------
    // Receive threshold code to characters
    function automatic logic [6:0] rx_level(input logic [1:0] code);
        case (code)
            2'b00:   rx_level = uff_pkg::UFF_LVL_8;
            2'b01:   rx_level = uff_pkg::UFF_LVL_16;
            2'b10:   rx_level = uff_pkg::UFF_LVL_56;
            default: rx_level = uff_pkg::UFF_LVL_60;
        endcase
    endfunction : rx_level

    // Transmit threshold code to free spaces
    function automatic logic [6:0] tx_level(input logic [1:0] code);
        case (code)
            2'b00:   tx_level = uff_pkg::UFF_LVL_8;
            2'b01:   tx_level = uff_pkg::UFF_LVL_16;
            2'b10:   tx_level = uff_pkg::UFF_LVL_32;
            default: tx_level = uff_pkg::UFF_LVL_56;
        endcase
    endfunction : tx_level

    // ----------------------------------------
    // Register access
    // ----------------------------------------
    uff_pkg::uff_fifo_cfg_t cfg, next_cfg;   // Stored FIFO fields
    logic [7:0]  efc, next_efc;              // enhanced_feature_control
    logic        txclr, next_txclr;          // Clear pulses
    logic        rxclr, next_rxclr;
    logic [7:0]  rdata, next_rdata;          // Read return
    logic        hit_fc;                     // fifo_control selected
    logic        hit_efc;                    // Enhanced bank selected

    assign hit_fc  = reg_addr_in == uff_pkg::UFF_OFS_FIFO_CTRL
                  && !line_control_in[uff_pkg::UFF_LC_DIVLATCH];
    assign hit_efc = reg_addr_in == uff_pkg::UFF_OFS_FIFO_CTRL
                  && line_control_in == uff_pkg::UFF_LC_ENH_KEY
                  && !extra_feature_lock_in;

    // Next register state; clear pulses last one cycle
    always_comb begin
        next_cfg   = cfg;
        next_efc   = efc;
        next_txclr = 1'b0;
        next_rxclr = 1'b0;
        next_rdata = rdata;
        if (reg_wr_in && hit_fc) begin
            // With FIFO mode off, every other field is frozen
            next_cfg.fifo_en = reg_wdata_in[uff_pkg::UFF_FC_EN];
            if (reg_wdata_in[uff_pkg::UFF_FC_EN]) begin
                next_cfg.rx_trig =
                    reg_wdata_in[uff_pkg::UFF_FC_RXTRG_LO +: 2];
                if (efc[uff_pkg::UFF_EF_ENH]) begin
                    next_cfg.tx_trig =
                        reg_wdata_in[uff_pkg::UFF_FC_TXTRG_LO +: 2];
                end
                next_txclr = reg_wdata_in[uff_pkg::UFF_FC_TXCLR];
                next_rxclr = reg_wdata_in[uff_pkg::UFF_FC_RXCLR];
            end
            // Bit 3 is never looked at
        end else if (reg_wr_in && hit_efc) begin
            next_efc = reg_wdata_in;
        end
        if (reg_rd_in) begin
            // fifo_control is write-only, so only the enhanced bank reads
            next_rdata = hit_efc ? efc : uff_pkg::UFF_RD_NONE;
        end
    end

    // Register stage for the access group
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cfg   <= {uff_pkg::UFF_FC_RST[7:4], uff_pkg::UFF_FC_RST[0]};
            efc   <= uff_pkg::UFF_EFC_RST;
            txclr <= 1'b0;
            rxclr <= 1'b0;
            rdata <= uff_pkg::UFF_RD_NONE;
        end else begin
            cfg   <= next_cfg;
            efc   <= next_efc;
            txclr <= next_txclr;
            rxclr <= next_rxclr;
            rdata <= next_rdata;
        end
    end

    assign fifo_cfg_out      = cfg;
    assign efc_out           = efc;
    assign reg_rdata_out     = rdata;
    assign tx_fifo_clear_out = txclr;   // Shift registers not touched
    assign rx_fifo_clear_out = rxclr;

    // ----------------------------------------
    // Depth and trigger levels
    // ----------------------------------------
    // Levels derive from stored fields only, so they glitch never
    assign fifo_depth_out    = cfg.fifo_en ? uff_pkg::UFF_DEPTH_FIFO
                                           : uff_pkg::UFF_LVL_ONE;
    assign rx_trig_level_out = cfg.fifo_en ? rx_level(cfg.rx_trig)
                                           : uff_pkg::UFF_LVL_ONE;
    assign tx_trig_level_out = cfg.fifo_en ? tx_level(cfg.tx_trig)
                                           : uff_pkg::UFF_LVL_ONE;
    assign rx_data_avail_out = rx_fill_in >= rx_trig_level_out;
    assign tx_ready_out      = tx_free_in >= tx_trig_level_out;

    // ----------------------------------------
    // Modem flow control
    // ----------------------------------------
    logic cts_s1, cts_s2, cts_s3;   // Pin synchroniser chain
    logic cts_q, next_cts_q;        // Filtered CTS level
    logic rts_n, next_rts_n;        // RTS pin drive

    // Accept a CTS change only once two stages agree
    always_comb begin
        next_cts_q = (cts_s2 == cts_s3) ? cts_s3 : cts_q;
        if (efc[uff_pkg::UFF_EF_RTS]) begin
            next_rts_n = rx_fill_in >= rx_trig_level_out;
        end else begin
            next_rts_n = !mcr_rts_in;
        end
    end

    // Sync chain; CTS idles inactive high
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cts_s1 <= 1'b1;
            cts_s2 <= 1'b1;
            cts_s3 <= 1'b1;
            cts_q  <= 1'b1;
            rts_n  <= 1'b1;
        end else begin
            cts_s1 <= cts_n_in;
            cts_s2 <= cts_s1;
            cts_s3 <= cts_s2;
            cts_q  <= next_cts_q;
            rts_n  <= next_rts_n;
        end
    end

    assign tx_cts_allow_out = !efc[uff_pkg::UFF_EF_CTS] || !cts_q;
    assign rts_n_out        = rts_n;

    // ----------------------------------------
    // Software flow control selects
    // ----------------------------------------
    logic [1:0] tx_sel;     // Transmitted pair selection
    logic [1:0] rx_sel;     // Compared pair selection
    logic       either;     // Either character counts
    logic       seq_mode;   // Two-character sequences
    logic       cmp1;       // Compare first characters
    logic       cmp2;       // Compare second characters

    assign tx_sel   = efc[uff_pkg::UFF_EF_TXSEL_LO +: 2];
    assign rx_sel   = efc[uff_pkg::UFF_EF_RXSEL_LO +: 2];
    assign either   = rx_sel == 2'b11
                   && (tx_sel == 2'b10 || tx_sel == 2'b01);
    assign seq_mode = rx_sel == 2'b11 && !either;
    assign cmp1     = rx_sel == 2'b10 || either;
    assign cmp2     = rx_sel == 2'b01 || either;
    assign tx_send_first_out  = tx_sel[1];
    assign tx_send_second_out = tx_sel[0];
    assign enh_unlock_out     = efc[uff_pkg::UFF_EF_ENH];
    assign sleep_allow_out    = efc[uff_pkg::UFF_EF_ENH]
                             && ier_sleep_in;

    // ----------------------------------------
    // Receive character classification
    // ----------------------------------------
    uff_pkg::uff_seq_t    seq_st, next_seq_st;   // Sequence tracker
    uff_pkg::uff_rx_evt_t evt, next_evt;         // Verdict pulses
    logic                 is_x2;                 // Byte is second pause

    assign is_x2 = rx_byte_in == pause_char_second_in;

    // Verdict for each byte; first of a broken pair is dropped
    always_comb begin
        next_evt    = '0;
        next_seq_st = seq_st;
        if (rx_byte_valid_in) begin
            if (seq_mode) begin
                case (seq_st)
                    uff_pkg::UFF_ST_IDLE: begin
                        if (rx_byte_in == resume_char_first_in) begin
                            next_seq_st = uff_pkg::UFF_ST_RES1;
                        end else if (rx_byte_in == pause_char_first_in) begin
                            next_seq_st = uff_pkg::UFF_ST_PAU1;
                        end else begin
                            next_evt.store = 1'b1;
                        end
                    end
                    uff_pkg::UFF_ST_RES1: begin
                        next_seq_st = uff_pkg::UFF_ST_IDLE;
                        next_evt.resume =
                            rx_byte_in == resume_char_second_in;
                        next_evt.store  = !next_evt.resume;
                    end
                    uff_pkg::UFF_ST_PAU1: begin
                        next_seq_st = uff_pkg::UFF_ST_IDLE;
                        next_evt.pause = is_x2;
                        next_evt.store = !is_x2;
                    end
                    default: begin
                        next_seq_st = uff_pkg::UFF_ST_IDLE;
                    end
                endcase
            end else begin
                next_seq_st = uff_pkg::UFF_ST_IDLE;
                if ((cmp1 && rx_byte_in == resume_char_first_in)
                    || (cmp2 && rx_byte_in == resume_char_second_in)) begin
                    next_evt.resume = 1'b1;
                end else if ((cmp1 && rx_byte_in == pause_char_first_in)
                             || (cmp2 && is_x2)) begin
                    next_evt.pause = 1'b1;
                end else begin
                    next_evt.store = 1'b1;
                end
            end
            // Flagged whether stored or consumed as a pause
            next_evt.special = efc[uff_pkg::UFF_EF_SPECIAL] && is_x2
                            && (next_evt.store || next_evt.pause);
        end else if (!seq_mode) begin
            next_seq_st = uff_pkg::UFF_ST_IDLE;
        end
    end

    // Register stage for classification
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            seq_st <= uff_pkg::UFF_ST_IDLE;
            evt    <= '0;
        end else begin
            seq_st <= next_seq_st;
            evt    <= next_evt;
        end
    end

    assign rx_evt_out = evt;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence fc_write_s;
        reg_wr_in && hit_fc && reg_wdata_in[uff_pkg::UFF_FC_EN];
    endsequence
    sequence pulse_tx_s;
        tx_fifo_clear_out ##1 !tx_fifo_clear_out;
    endsequence

    AST_RX_LEVEL: assert property (cfg.fifo_en && cfg.rx_trig == 2'b10
        |-> rx_trig_level_out == 7'h38)
        else $error("receive level wrong");
    AST_TX_LEVEL: assert property (cfg.fifo_en && cfg.tx_trig == 2'b10
        |-> tx_trig_level_out == 7'h20)
        else $error("transmit level wrong");
    AST_TX_CLEAR: assert property (fc_write_s
        and reg_wdata_in[uff_pkg::UFF_FC_TXCLR] |=> pulse_tx_s)
        else $error("transmit clear not a pulse");
    AST_RX_CLEAR: assert property (fc_write_s
        and reg_wdata_in[uff_pkg::UFF_FC_RXCLR]
        |=> rx_fifo_clear_out ##1 !rx_fifo_clear_out)
        else $error("receive clear not a pulse");
    AST_ONE_CHAR: assert property (!cfg.fifo_en |-> fifo_depth_out == 7'h01
        && rx_trig_level_out == 7'h01)
        else $error("non-FIFO level not one");
    AST_TXTRIG_LOCK: assert property (reg_wr_in && hit_fc
        && !efc[uff_pkg::UFF_EF_ENH] |=> $stable(cfg.tx_trig))
        else $error("transmit trigger changed while locked");
    AST_EFC_GATE: assert property (reg_wr_in && !hit_efc
        |=> $stable(efc))
        else $error("enhanced register written without key");
    AST_CTS_HOLD: assert property (efc[uff_pkg::UFF_EF_CTS] && cts_q
        |-> !tx_cts_allow_out)
        else $error("transmit allowed with CTS inactive");
    AST_SEQ_RESUME: assert property (seq_mode && rx_byte_valid_in
        && seq_st == uff_pkg::UFF_ST_RES1
        && rx_byte_in == resume_char_second_in
        |=> rx_evt_out.resume && !rx_evt_out.store)
        else $error("resume pair not recognised");
    AST_SPECIAL: assert property (rx_byte_valid_in && is_x2
        && efc[uff_pkg::UFF_EF_SPECIAL] && !seq_mode
        |=> rx_evt_out.special)
        else $error("special character not flagged");
endmodule : uff_fifo_flow_cfg

/* uff_fifo_flow_cfg_tb.sv */
`timescale 1ns/1ns
module uff_fifo_flow_cfg_tb;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk_in, rst_in, lock, sleep, mrts, cts_n, rxv, txc, rxc, avail;
    logic txr, allow, rts_n, s1, s2, unl, slp, wr, rd;
    logic [2:0] addr;
    logic [7:0] wd, rdat, line_control, rxb, efc, q;
    logic [6:0] fill, free, depth, rxl, txl;
    uff_pkg::uff_fifo_cfg_t cfg;
    uff_pkg::uff_rx_evt_t   evt;
    int fails = 0;
    int n_tests = 0;

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    uff_host u_host (.clk_in(clk_in), .reg_rdata_in(rdat),
        .reg_addr_out(addr), .reg_wr_out(wr), .reg_rd_out(rd),
        .reg_wdata_out(wd), .line_control_out(line_control));

    uff_fifo_flow_cfg u_dut (.clk_in(clk_in), .rst_in(rst_in),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_wdata_in(wd), .reg_rdata_out(rdat), .line_control_in(line_control),
        .extra_feature_lock_in(lock), .ier_sleep_in(sleep),
        .mcr_rts_in(mrts), .cts_n_in(cts_n), .rx_byte_valid_in(rxv),
        .rx_byte_in(rxb), .resume_char_first_in(8'h11),
        .resume_char_second_in(8'h12), .pause_char_first_in(8'h13),
        .pause_char_second_in(8'h14), .rx_fill_in(fill),
        .tx_free_in(free), .fifo_cfg_out(cfg), .efc_out(efc),
        .fifo_depth_out(depth), .rx_trig_level_out(rxl),
        .tx_trig_level_out(txl), .tx_fifo_clear_out(txc),
        .rx_fifo_clear_out(rxc), .rx_data_avail_out(avail),
        .tx_ready_out(txr), .tx_cts_allow_out(allow), .rts_n_out(rts_n),
        .rx_evt_out(evt), .tx_send_first_out(s1),
        .tx_send_second_out(s2), .enh_unlock_out(unl),
        .sleep_allow_out(slp));

    // ----------------------------------------
    // Shared compare, close-out and drivers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    // One received byte; verdict stands in the following cycle
    task automatic rx(input logic [7:0] b);
        @(negedge clk_in);
        rxv = 1'b1;
        rxb = b;
        @(negedge clk_in);
        rxv = 1'b0;
        rxb = ~b;
    endtask : rx

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk("cfg", 8'h00, {3'h0, cfg});
        chk("efc", 8'h00, efc);
        chk("depth", 8'h01, {1'b0, depth});
        chk("rts_n", 8'h01, {7'h0, rts_n});
    endtask : t_reset

    // Trigger tables, self-clearing resets, gating of the tx field
    task automatic t_fcr;
        logic [6:0] rt[4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
        logic [6:0] tt[4] = '{7'h08, 7'h10, 7'h20, 7'h38};
        u_host.wr(8'h03, 3'h2, 8'h77);
        chk("cfg", 8'h09, {3'h0, cfg});
        chk("clr", 8'h03, {6'h0, txc, rxc});
        @(negedge clk_in);
        chk("clr", 8'h00, {6'h0, txc, rxc});
        chk("depth", 8'h40, {1'b0, depth});
        for (int i = 0; i < 4; i++) begin
            u_host.wr(8'h03, 3'h2, {i[1:0], 6'h01});
            chk("rxl", {1'b0, rt[i]}, {1'b0, rxl});
        end
        u_host.wr(8'hBF, 3'h2, 8'h10);
        for (int i = 0; i < 4; i++) begin
            u_host.wr(8'h03, 3'h2, {2'b00, i[1:0], 4'h9});
            chk("txl", {1'b0, tt[i]}, {1'b0, txl});
        end
        u_host.wr(8'h83, 3'h2, 8'hC1);
        chk("cfg", 8'h07, {3'h0, cfg});
        u_host.wr(8'h03, 3'h2, 8'hC6);
        chk("cfg", 8'h06, {3'h0, cfg});
        chk("clr", 8'h00, {6'h0, txc, rxc});
        chk("lvl", 8'h11, {rxl[3:0], txl[3:0]});
        u_host.wr(8'h03, 3'h2, 8'hB1);
        fill = 7'h37;
        free = 7'h37;
        #1 chk("lo", 8'h00, {6'h0, avail, txr});
        fill = 7'h38;
        free = 7'h38;
        #1 chk("hi", 8'h03, {6'h0, avail, txr});
    endtask : t_fcr

    // Enhanced bank key, lock, readback and enable gates
    task automatic t_efc;
        lock = 1'b1;
        u_host.wr(8'hBF, 3'h2, 8'hFF);
        lock = 1'b0;
        u_host.rd(8'hBF, 3'h2, q);
        chk("efc", 8'h10, q);
        u_host.wr(8'hBF, 3'h2, 8'hC5);
        u_host.rd(8'hBF, 3'h2, q);
        chk("efc", 8'hC5, q);
        chk("gate", 8'h00, {6'h0, unl, slp});
        sleep = 1'b1;
        #1 chk("sleep", 8'h00, {7'h0, slp});
        u_host.wr(8'hBF, 3'h2, 8'h18);
        chk("gate", 8'h07, {5'h0, unl, slp, s1});
        chk("efc_out", 8'h18, efc);
        chk("send2", 8'h00, {7'h0, s2});
        u_host.rd(8'hBF, 3'h3, q);
        chk("unmapped", 8'h00, q);
    endtask : t_efc

    // Byte verdicts for each comparison mode
    task automatic t_rx;
        logic [7:0] m[8] = '{8'h20, 8'h21, 8'h22, 8'h22, 8'h0B, 8'h07,
                             8'h00, 8'h22};
        logic [7:0] b[8] = '{8'h14, 8'h14, 8'h13, 8'h11, 8'h14, 8'h12,
                             8'h13, 8'h55};
        logic [3:0] e[8] = '{4'h9, 4'h3, 4'h2, 4'h4, 4'h2, 4'h4,
                             4'h8, 4'h8};
        for (int i = 0; i < 8; i++) begin
            u_host.wr(8'hBF, 3'h2, m[i]);
            rx(b[i]);
            chk("evt", {4'h0, e[i]}, {4'h0, evt});
            if (i == 5) chk("send", 8'h01, {6'h0, s1, s2});
        end
        u_host.wr(8'hBF, 3'h2, 8'h03);
        rx(8'h13);
        chk("seq1", 8'h00, {4'h0, evt});
        rx(8'h14);
        chk("seq2", 8'h02, {4'h0, evt});
        // Both pairs sent; resume pair completes, broken pair keeps 2nd
        u_host.wr(8'hBF, 3'h2, 8'h0F);
        chk("send", 8'h03, {6'h0, s1, s2});
        rx(8'h11);
        chk("seq3", 8'h00, {4'h0, evt});
        rx(8'h12);
        chk("seq4", 8'h04, {4'h0, evt});
        rx(8'h11);
        rx(8'h55);
        chk("seq5", 8'h08, {4'h0, evt});
    endtask : t_rx

    // CTS pacing and software RTS
    task automatic t_flow;
        u_host.wr(8'hBF, 3'h2, 8'h80);
        cts_n = 1'b1;
        repeat (8) @(negedge clk_in);
        chk("cts", 8'h00, {7'h0, allow});
        cts_n = 1'b0;
        repeat (8) @(negedge clk_in);
        chk("cts", 8'h01, {7'h0, allow});
        u_host.wr(8'hBF, 3'h2, 8'h00);
        cts_n = 1'b1;
        repeat (8) @(negedge clk_in);
        chk("cts", 8'h01, {7'h0, allow});
        mrts = 1'b1;
        repeat (2) @(negedge clk_in);
        chk("rts", 8'h00, {7'h0, rts_n});
        // Automatic RTS follows the receive fill against its 56 level
        u_host.wr(8'hBF, 3'h2, 8'h40);
        repeat (2) @(negedge clk_in);
        chk("auto_rts", 8'h01, {7'h0, rts_n});
        fill = 7'h37;
        repeat (2) @(negedge clk_in);
        chk("auto_rts", 8'h00, {7'h0, rts_n});
    endtask : t_flow

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        rst_in = 1'b1;
        {lock, sleep, mrts, cts_n, rxv} = 5'b00000;
        rxb = 8'h00;
        fill = 7'h00;
        free = 7'h00;
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        t_reset();
        t_fcr();
        t_efc();
        t_rx();
        t_flow();
        results();
    end

    // Whole run is about 125 cycles; this is far past it
    initial begin
        #100000;
        fails++;
        results();
    end
endmodule : uff_fifo_flow_cfg_tb

/* uff_host.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Host processor model on the register port
// ----------------------------------------
module uff_host (
    input  wire logic       clk_in,
    input  wire logic [7:0] reg_rdata_in,
    output logic      [2:0] reg_addr_out,
    output logic            reg_wr_out,
    output logic            reg_rd_out,
    output logic      [7:0] reg_wdata_out,
    output logic      [7:0] line_control_out
);
    // Idle bus at time zero, address parked off the shared offset
    initial begin
        reg_addr_out     = 3'h0;
        reg_wr_out       = 1'b0;
        reg_rd_out       = 1'b0;
        reg_wdata_out    = 8'h00;
        line_control_out = 8'h00;
    end

    // Write: strobe held over one rising edge, dropped at the next fall
    task automatic wr(input logic [7:0] line_control, input logic [2:0] a,
                      input logic [7:0] d);
        @(negedge clk_in);
        line_control_out = line_control;
        reg_addr_out     = a;
        reg_wdata_out    = d;
        reg_wr_out       = 1'b1;
        @(negedge clk_in);
        reg_wr_out       = 1'b0;
        // Released lines show junk so a stale value cannot pass
        reg_addr_out     = ~a;
        reg_wdata_out    = ~d;
    endtask : wr

    // Read: data is registered, so it stands once the strobe drops
    task automatic rd(input logic [7:0] line_control, input logic [2:0] a,
                      output logic [7:0] q);
        @(negedge clk_in);
        line_control_out = line_control;
        reg_addr_out     = a;
        reg_rd_out       = 1'b1;
        @(negedge clk_in);
        reg_rd_out       = 1'b0;
        reg_addr_out     = ~a;
        q                = reg_rdata_in;
    endtask : rd
endmodule : uff_host

/* uff_pkg.sv */
package uff_pkg;
    // ----------------------------------------
    // Register offsets and access keys
    // ----------------------------------------
    localparam logic [2:0] UFF_OFS_FIFO_CTRL = 3'h2; // Shared by both regs
    localparam int         UFF_LC_DIVLATCH   = 7;    // Divisor latch select
    localparam logic [7:0] UFF_LC_ENH_KEY    = 8'hBF; // Enhanced bank key
    localparam logic [7:0] UFF_FC_RST        = 8'h00;
    localparam logic [7:0] UFF_EFC_RST       = 8'h00;
    localparam logic [7:0] UFF_RD_NONE       = 8'h00; // Unmapped read value

    // ----------------------------------------
    // fifo_control field positions
    // ----------------------------------------
    localparam int UFF_FC_EN       = 0;
    localparam int UFF_FC_RXCLR    = 1;
    localparam int UFF_FC_TXCLR    = 2;
    localparam int UFF_FC_TXTRG_LO = 4;
    localparam int UFF_FC_RXTRG_LO = 6;

    // ----------------------------------------
    // enhanced_feature_control field positions
    // ----------------------------------------
    localparam int UFF_EF_CTS      = 7;
    localparam int UFF_EF_RTS      = 6;
    localparam int UFF_EF_SPECIAL  = 5;
    localparam int UFF_EF_ENH      = 4;
    localparam int UFF_EF_TXSEL_LO = 2;
    localparam int UFF_EF_RXSEL_LO = 0;

    // ----------------------------------------
    // Depths and trigger levels in characters
    // ----------------------------------------
    localparam logic [6:0] UFF_DEPTH_FIFO = 7'h40; // 64
    localparam logic [6:0] UFF_LVL_ONE    = 7'h01;
    localparam logic [6:0] UFF_LVL_8      = 7'h08;
    localparam logic [6:0] UFF_LVL_16     = 7'h10;
    localparam logic [6:0] UFF_LVL_32     = 7'h20;
    localparam logic [6:0] UFF_LVL_56     = 7'h38;
    localparam logic [6:0] UFF_LVL_60     = 7'h3C;

    // Stored fifo_control fields
    typedef struct packed {
        logic [1:0] rx_trig;
        logic [1:0] tx_trig;
        logic       fifo_en;
    } uff_fifo_cfg_t;

    // Per received byte verdict, one-cycle pulses
    typedef struct packed {
        logic store;   // Byte goes into the receive FIFO
        logic resume;  // Flow resume seen
        logic pause;   // Flow pause seen
        logic special; // Special character seen
    } uff_rx_evt_t;

    // Two-character sequence tracker
    typedef enum logic [2:0] {
        UFF_ST_IDLE = 3'b001,
        UFF_ST_RES1 = 3'b010,
        UFF_ST_PAU1 = 3'b100
    } uff_seq_t;
endpackage : uff_pkg
